// [rtl/lcd_defs.svh]
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH

// clock and execution timing
`define LCD_CLK_MHZ 250
`define LCD_T_SHORT_NS 26300
`define LCD_T_LONG_NS 1080000
`define LCD_T_BLINK_MS 400
`define LCD_BUSY_W 20
`define LCD_BLINK_W 27

// bus map (byte addresses within the slave window)
`define LCD_OFF_CMD 4'h0
`define LCD_OFF_DATA 4'h4
`define LCD_RESP_OKAY 2'h0
`define LCD_RESP_SLVERR 2'h2

// text memory layout
`define LCD_SPACE_CODE 8'h20
`define LCD_ADDR_HOME 7'h00
`define LCD_LINE1_END 7'h27
`define LCD_LINE2_BEG 7'h40
`define LCD_LINE2_END 7'h67
`define LCD_ONE_LINE_END 7'h4F
`define LCD_FILL_LAST 7'h7F
`define LCD_SHIFT_LAST 6'h27

// opcodes
`define LCD_OP_CLEAR 8'h01

// reset values
`define LCD_RST_BUS8 1'h1
`define LCD_RST_INC 1'h1

`endif

// [rtl/lcd_instr_decoder.sv]
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`include "lcd_defs.svh"
`default_nettype none
module lcd_instr_decoder #(
    parameter int unsigned ADDR_W = 4,
    parameter int unsigned SHORT_CYCLES =
        `LCD_T_SHORT_NS * `LCD_CLK_MHZ / 1000,
    parameter int unsigned LONG_CYCLES =
        `LCD_T_LONG_NS * `LCD_CLK_MHZ / 1000,
    parameter int unsigned BLINK_CYCLES =
        `LCD_T_BLINK_MS * `LCD_CLK_MHZ * 1000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // strap
    input wire logic extended_set_pin,
    // axi4-lite write
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // display side
    output logic busy_indicator,
    output lcd_pkg::lcd_view_s view
);

    localparam logic [19:0] SHORT_LOAD = 20'(SHORT_CYCLES);
    localparam logic [19:0] LONG_LOAD = 20'(LONG_CYCLES);
    localparam logic [26:0] BLINK_LAST = 27'(BLINK_CYCLES - 1);

    lcd_pkg::lcd_state_s s;
    lcd_pkg::lcd_state_s next_s;
    logic [7:0] text_mem [128];
    logic [7:0] glyph_mem [64];
    logic [7:0] symbol_mem [16];
    logic text_we;
    logic glyph_we;
    logic symbol_we;
    logic [6:0] mem_wa;
    logic [7:0] mem_wd;
    logic busy;
    logic tall_eff;
    logic wr_go;
    logic rd_go;
    logic wr_map;
    logic rd_map;
    logic wr_is_data;
    logic rd_is_data;
    logic exec_cmd;
    logic exec_data;
    logic exec_read;
    logic [7:0] op;
    logic [7:0] rd_byte;
    logic [6:0] stepped;

    // memory read helper; unused enum codes read as zero
    function automatic logic [7:0] mem_rd(lcd_pkg::lcd_mem_e m,
                                          logic [6:0] a);
        unique case (m)
            lcd_pkg::LCD_MEM_TEXT: mem_rd = text_mem[a];
            lcd_pkg::LCD_MEM_GLYPH: mem_rd = glyph_mem[a[5:0]];
            lcd_pkg::LCD_MEM_SYMBOL: mem_rd = symbol_mem[a[3:0]];
            default: mem_rd = 8'h00;
        endcase
    endfunction : mem_rd

    // next pointer value, wrapping inside the valid window of each memory
    function automatic logic [6:0] step_addr(lcd_pkg::lcd_mem_e m,
                                             logic [6:0] a, logic up,
                                             logic two, logic tall);
        logic [6:0] last;
        last = tall ? `LCD_LINE1_END : `LCD_ONE_LINE_END;
        step_addr = a;
        unique case (m)
            lcd_pkg::LCD_MEM_GLYPH:
                step_addr = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
            lcd_pkg::LCD_MEM_SYMBOL:
                step_addr = {3'h0, up ? a[3:0] + 4'h1 : a[3:0] - 4'h1};
            lcd_pkg::LCD_MEM_TEXT: begin
                if (two) begin
                    if (up) begin
                        step_addr = (a == `LCD_LINE1_END) ? `LCD_LINE2_BEG :
                                    (a == `LCD_LINE2_END) ? `LCD_ADDR_HOME :
                                    a + 7'h01;
                    end else begin
                        step_addr = (a == `LCD_LINE2_BEG) ? `LCD_LINE1_END :
                                    (a == `LCD_ADDR_HOME) ? `LCD_LINE2_END :
                                    a - 7'h01;
                    end
                end else begin
                    if (up) begin
                        step_addr = (a >= last) ? `LCD_ADDR_HOME : a + 7'h01;
                    end else begin
                        step_addr = (a == `LCD_ADDR_HOME || a > last) ?
                                    last : a - 7'h01;
                    end
                end
            end
            default: step_addr = a;
        endcase
    endfunction : step_addr

    // display offset kept in one line length so every line wraps alike
    function automatic logic [5:0] shift_step(logic [5:0] off, logic left);
        if (left) begin
            shift_step = (off >= `LCD_SHIFT_LAST) ? 6'h00 : off + 6'h01;
        end else begin
            shift_step = (off == 6'h00) ? `LCD_SHIFT_LAST : off - 6'h01;
        end
    endfunction : shift_step

    // clear fill keeps the decoder busy even if the count is shortened
    // busy gates instructions
    assign busy = (s.busy_cnt != 20'h00000) | s.filling;
    // tall with two lines never combined by host
    assign tall_eff = s.tall & ~s.two_line & ~extended_set_pin;
    assign wr_map = (awaddr[ADDR_W-1:0] == `LCD_OFF_CMD) |
                    (awaddr[ADDR_W-1:0] == `LCD_OFF_DATA);
    assign rd_map = (araddr[ADDR_W-1:0] == `LCD_OFF_CMD) |
                    (araddr[ADDR_W-1:0] == `LCD_OFF_DATA);
    assign wr_is_data = (awaddr[ADDR_W-1:0] == `LCD_OFF_DATA);
    assign rd_is_data = (araddr[ADDR_W-1:0] == `LCD_OFF_DATA);
    // a read waits one cycle when a write is taken, so they never collide
    assign wr_go = awvalid & wvalid & ~s.bvalid;
    assign rd_go = arvalid & ~s.rvalid & ~wr_go;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = rd_go;

    // next-state logic: bus slave, nibble pairing, decode and execution
    always_comb begin
        next_s = s;
        text_we = 1'b0;
        glyph_we = 1'b0;
        symbol_we = 1'b0;
        mem_wa = s.addr;
        mem_wd = 8'h00;
        exec_cmd = 1'b0;
        exec_data = 1'b0;
        exec_read = 1'b0;
        op = 8'h00;
        rd_byte = 8'h00;
        stepped = step_addr(s.sel, s.addr, s.inc, s.two_line, tall_eff);
        if (s.busy_cnt != 20'h00000) begin
            next_s.busy_cnt = s.busy_cnt - 20'h00001;
        end
        if (s.filling) begin
            text_we = 1'b1;
            mem_wa = s.fill_idx;
            mem_wd = `LCD_SPACE_CODE;
            next_s.fill_idx = s.fill_idx + 7'h01;
            if (s.fill_idx == `LCD_FILL_LAST) begin
                next_s.filling = 1'b0;
            end
        end
        if (s.blink_cnt >= BLINK_LAST) begin
            next_s.blink_cnt = 27'h0000000;
            next_s.blink_phase = ~s.blink_phase;
        end else begin
            next_s.blink_cnt = s.blink_cnt + 27'h0000001;
        end
        if (s.bvalid & bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid & rready) begin
            next_s.rvalid = 1'b0;
        end
        // write channel: refused while busy, lane 0 carries the byte
        if (wr_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = `LCD_RESP_OKAY;
            if (!wr_map || busy) begin
                next_s.bresp = `LCD_RESP_SLVERR;
            end else if (wstrb[0]) begin
                if (!s.bus8 && !s.nib_phase) begin
                    next_s.nib_hi = wdata[3:0];
                    next_s.nib_phase = 1'b1;
                end else begin
                    op = s.bus8 ? wdata[7:0] : {s.nib_hi, wdata[3:0]};
                    next_s.nib_phase = 1'b0;
                    exec_data = wr_is_data;
                    exec_cmd = ~wr_is_data;
                end
            end
        end
        // read channel: status is always answered, data only when idle
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `LCD_RESP_OKAY;
            next_s.rdata = 8'h00;
            if (!rd_map || (rd_is_data && busy)) begin
                next_s.rresp = `LCD_RESP_SLVERR;
            end else begin
                rd_byte = rd_is_data ? s.read_buf : {busy, s.addr};
                if (s.bus8) begin
                    next_s.rdata = rd_byte;
                    exec_read = rd_is_data;
                end else if (!s.nib_phase) begin
                    next_s.rdata = {4'h0, rd_byte[7:4]};
                    next_s.nib_phase = 1'b1;
                end else begin
                    next_s.rdata = {4'h0, rd_byte[3:0]};
                    next_s.nib_phase = 1'b0;
                    exec_read = rd_is_data;
                end
            end
        end
        if (exec_read) begin
            next_s.addr = stepped;
            next_s.read_buf = mem_rd(s.sel, stepped);
            next_s.busy_cnt = SHORT_LOAD;
        end
        // data write into the selected memory
        if (exec_data) begin
            text_we = (s.sel == lcd_pkg::LCD_MEM_TEXT);
            glyph_we = (s.sel == lcd_pkg::LCD_MEM_GLYPH);
            symbol_we = (s.sel == lcd_pkg::LCD_MEM_SYMBOL);
            mem_wa = s.addr;
            mem_wd = op;
            next_s.addr = stepped;
            next_s.busy_cnt = SHORT_LOAD;
            if (s.shift_on_write && s.sel == lcd_pkg::LCD_MEM_TEXT) begin
                next_s.shift_off = shift_step(s.shift_off, s.inc);
            end
        end
        // instruction decode
        if (exec_cmd) begin
            next_s.busy_cnt = SHORT_LOAD;
            if (op[7]) begin
                next_s.addr = op[6:0];
                next_s.sel = lcd_pkg::LCD_MEM_TEXT;
                next_s.read_buf = text_mem[op[6:0]];
            end else if (op[6]) begin
                if (!s.table_ext) begin
                    next_s.addr = {1'b0, op[5:0]};
                    next_s.sel = lcd_pkg::LCD_MEM_GLYPH;
                    next_s.read_buf = glyph_mem[op[5:0]];
                end else if (op[5:4] == 2'h0) begin
                    next_s.addr = {3'h0, op[3:0]};
                    next_s.sel = lcd_pkg::LCD_MEM_SYMBOL;
                    next_s.read_buf = symbol_mem[op[3:0]];
                end
            end else if (op[5]) begin
                next_s.bus8 = op[4];
                next_s.two_line = op[3];
                next_s.tall = op[2];
                next_s.table_ext = op[0];
            end else if (op[4]) begin
                if (!s.table_ext) begin
                    if (op[3]) begin
                        next_s.shift_off = shift_step(s.shift_off, ~op[2]);
                    end else begin
                        next_s.addr = step_addr(lcd_pkg::LCD_MEM_TEXT,
                                                s.addr, op[2], s.two_line,
                                                tall_eff);
                    end
                end
            end else if (op[3]) begin
                next_s.display_on = op[2];
                next_s.cursor_on = op[1];
                next_s.blink_on = op[0];
            end else if (op[2]) begin
                next_s.inc = op[1];
                next_s.shift_on_write = op[0];
            end else if (op[1]) begin
                next_s.addr = `LCD_ADDR_HOME;
                next_s.shift_off = 6'h00;
                next_s.sel = lcd_pkg::LCD_MEM_TEXT;
                next_s.busy_cnt = LONG_LOAD;
            end else if (op == `LCD_OP_CLEAR) begin
                next_s.filling = 1'b1;
                next_s.fill_idx = 7'h00;
                next_s.addr = `LCD_ADDR_HOME;
                next_s.shift_off = 6'h00;
                next_s.inc = 1'b1;
                next_s.sel = lcd_pkg::LCD_MEM_TEXT;
                next_s.busy_cnt = LONG_LOAD;
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.sel <= lcd_pkg::LCD_MEM_TEXT;
            s.bus8 <= `LCD_RST_BUS8;
            s.inc <= `LCD_RST_INC;
        end else begin
            s <= next_s;
        end
    end

    // memories carry no reset; contents are undefined until written, and clear fills only the text memory
    always_ff @(posedge aclk) begin
        if (text_we) begin
            text_mem[mem_wa] <= mem_wd;
        end
        if (glyph_we) begin
            glyph_mem[mem_wa[5:0]] <= mem_wd;
        end
        if (symbol_we) begin
            symbol_mem[mem_wa[3:0]] <= mem_wd;
        end
    end

    // outputs
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = {24'h000000, s.rdata};
    assign busy_indicator = busy;
    assign view = '{
        display_on: s.display_on,
        cursor_on: s.cursor_on,
        blink_on: s.blink_on,
        cursor_all_dots: s.display_on & s.blink_on & s.blink_phase,
        two_line: s.two_line,
        font_tall: tall_eff,
        table_ext: s.table_ext,
        bus8: s.bus8,
        shift_off: s.shift_off,
        addr: s.addr,
        sel: s.sel
    };

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_clear_start: assert property (exec_cmd && op == `LCD_OP_CLEAR |=>
        s.filling && s.addr == 7'h00 && s.inc && busy)
        else $error("clear did not start fill");
    a_home_zero: assert property (exec_cmd && op[7:1] == 7'h01 |=>
        s.addr == 7'h00 && s.shift_off == 6'h00 && !s.filling)
        else $error("home did not reset pointer");
    a_glyph_step: assert property (exec_data && s.inc &&
        s.sel == lcd_pkg::LCD_MEM_GLYPH |=>
        s.addr[5:0] == $past(s.addr[5:0]) + 6'h01)
        else $error("glyph pointer did not step up");
    a_line_wrap: assert property (exec_data && s.inc && s.two_line &&
        s.sel == lcd_pkg::LCD_MEM_TEXT && s.addr == 7'h27 |=>
        s.addr == 7'h40)
        else $error("cursor did not move to line two");
    a_busy_refuse: assert property (wr_go && busy |=>
        s.bresp == `LCD_RESP_SLVERR && $stable(s.addr) && bvalid)
        else $error("write accepted while busy");
    a_busy_length: assert property (exec_cmd && op[7:2] != 6'h00 |=>
        s.busy_cnt == SHORT_LOAD ##1 busy [*3])
        else $error("busy time wrong");
    a_status_byte: assert property (rd_go && !rd_is_data && rd_map &&
        s.bus8 |=> rvalid && rdata[7:0] == {$past(busy), $past(s.addr)})
        else $error("status byte wrong");
    a_strap_font: assert property (extended_set_pin |->
        !view.font_tall)
        else $error("tall font while strap high");
    a_shift_keep: assert property (exec_cmd && op[7:3] == 5'h03 &&
        !s.table_ext |=> $stable(s.addr))
        else $error("display shift moved pointer");

    c_clear_done: cover property (s.filling ##1 !s.filling);
    c_nibble_pair: cover property (!s.bus8 && exec_cmd);
    c_symbol_set: cover property (s.sel == lcd_pkg::LCD_MEM_SYMBOL);
    c_busy_drop: cover property (busy ##1 !busy);

endmodule : lcd_instr_decoder
`default_nettype wire

// [rtl/lcd_pkg.sv]
`default_nettype none
package lcd_pkg;

    // memory that data accesses are aimed at
    typedef enum logic [2:0] {
        LCD_MEM_TEXT = 3'b001,
        LCD_MEM_GLYPH = 3'b010,
        LCD_MEM_SYMBOL = 3'b100
    } lcd_mem_e;

    // display-facing view of the controller settings
    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic cursor_all_dots;
        logic two_line;
        logic font_tall;
        logic table_ext;
        logic bus8;
        logic [5:0] shift_off;
        logic [6:0] addr;
        lcd_mem_e sel;
    } lcd_view_s;

    // register state of the decoder apart from the text, glyph and symbol memories
    typedef struct packed {
        logic [19:0] busy_cnt;
        logic filling;
        logic [6:0] fill_idx;
        logic [6:0] addr;
        lcd_mem_e sel;
        logic inc;
        logic shift_on_write;
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic bus8;
        logic two_line;
        logic tall;
        logic table_ext;
        logic [5:0] shift_off;
        logic nib_phase;
        logic [3:0] nib_hi;
        logic [7:0] read_buf;
        logic [26:0] blink_cnt;
        logic blink_phase;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } lcd_state_s;

endpackage : lcd_pkg
`default_nettype wire

// [testbench/lcd_host_model.sv]
`default_nettype none
module lcd_host_model (
    // clock
    input wire logic aclk,
    // write channels
    output logic [31:0] awaddr,
    output logic awvalid,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read channels
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // released lines show the inverse, never a stale copy
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do @(posedge aclk); while (!(awready && wready));
        {awvalid, wvalid} <= 2'b00;
        awaddr <= ~a;
        wdata <= ~d;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // read: rready held until the answer
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : lcd_host_model
`default_nettype wire

// [testbench/test_char_lcd_instruction_decoder.sv]
`include "lcd_defs.svh"
`default_nettype none
module test_char_lcd_instruction_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, extended_set_pin, busy_indicator, nib4;
    logic [31:0] awaddr, wdata, araddr, rdata, x;
    logic awvalid, wvalid, awready, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] b, m [4];
    logic [6:0] p;
    lcd_pkg::lcd_view_s view;
    int failures, cmp_count, n;
    // short counts keep the run brief
    lcd_instr_decoder #(.SHORT_CYCLES(8), .LONG_CYCLES(200),
        .BLINK_CYCLES(16)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .extended_set_pin(extended_set_pin),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .busy_indicator(busy_indicator), .view(view)
    );
    lcd_host_model host (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .wdata(wdata), .wvalid(wvalid), .awready(awready),
        .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready)
    );
    // expected text pointer after one upward step in two-line mode
    function automatic logic [6:0] next_text(input logic [6:0] a);
        if (a == `LCD_LINE1_END) return `LCD_LINE2_BEG;
        if (a == `LCD_LINE2_END) return `LCD_ADDR_HOME;
        return a + 7'h01;
    endfunction : next_text
    // free-running clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // hang guard
    initial begin
        #240000;
        failures++;
        complete_run();
    end
    task automatic complete_run();
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %0t: got %0h want %0h", $time, g, e);
        end
    endtask : chk
    // narrow bus sends high half first
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        if (nib4) host.wr({28'h0, a}, {28'h0, d[7:4]}, r);
        host.wr({28'h0, a}, nib4 ? {28'h0, d[3:0]} : {24'h0, d}, r);
    endtask : put
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        host.rd({28'h0, a}, x, r);
        d = x[7:0];
        if (nib4) begin
            host.rd({28'h0, a}, x, r);
            d = {d[3:0], x[3:0]};
        end
    endtask : get
    // poll status until not busy; a stuck flag is a mismatch
    task automatic idle();
        for (int i = 0; i < 400; i++) begin
            get(4'h0, b);
            if (b[7] === 1'b0) break;
        end
        if (b[7] !== 1'b0) begin
            failures++;
            $display("Error %0t: busy never dropped", $time);
        end
    endtask : idle
    task automatic cmd(input logic [7:0] op);
        put(4'h0, op);
        idle();
    endtask : cmd
    task automatic dat(input logic [7:0] d);
        put(4'h4, d);
        idle();
    endtask : dat
    task automatic rdd(output logic [7:0] d);
        get(4'h4, d);
        idle();
    endtask : rdd
    task automatic st(input logic [7:0] e);
        get(4'h0, b);
        chk(b, e);
    endtask : st
    // main sequence
    initial begin
        {aresetn, extended_set_pin, nib4, awprot, arprot} = '0;
        wstrb = 4'hF;
        failures = 0;
        cmp_count = 0;
        void'($urandom(32'h7ef9));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        st(8'h00);
        cmd(8'h38);
        chk(view.two_line, 1'b1);
        // long clear: busy, refusal, duration
        put(4'h0, `LCD_OP_CLEAR);
        st(8'h80);
        host.wr(32'h4, 32'h55, r);
        chk(r, `LCD_RESP_SLVERR);
        for (n = 0; n < 1000 && busy_indicator !== 1'b0; n++)
            @(posedge aclk);
        chk(n >= 180 && n <= 340, 1'b1);
        st(8'h00);
        cmd(8'h90);
        rdd(b);
        chk(b, `LCD_SPACE_CODE);
        // random text, stepping and readback
        cmd(8'h06);
        cmd(8'h85);
        for (int i = 0; i < 4; i++) begin
            m[i] = 8'($urandom);
            dat(m[i]);
        end
        st(8'h09);
        cmd(8'h85);
        for (int i = 0; i < 4; i++) begin
            rdd(b);
            chk(b, m[i]);
        end
        cmd(8'h04);
        dat(8'hA5);
        st(8'h08);
        // stale first read after a write, second read is good
        rdd(b);
        rdd(b);
        chk(b, m[2]);
        // glyph memory and shift on write
        cmd(8'h06);
        cmd(8'h43);
        chk(view.sel, lcd_pkg::LCD_MEM_GLYPH);
        dat(8'h1F);
        st(8'h04);
        cmd(8'h07);
        cmd(8'h43);
        rdd(b);
        chk(b, 8'h1F);
        dat(8'h11);
        chk(view.shift_off, 6'h00);
        cmd(8'h80);
        dat(8'h22);
        chk(view.shift_off, 6'h01);
        // cursor and display shift, wrap
        cmd(8'h06);
        cmd(8'h14);
        st(8'h02);
        cmd(8'h10);
        cmd(8'h18);
        st(8'h01);
        chk(view.shift_off, 6'h02);
        cmd(8'hA7);
        dat(8'h33);
        st(8'h40);
        cmd(8'hA7);
        cmd(8'h14);
        st(8'h40);
        // random run across the line boundary
        p = 7'h24 + 7'($urandom % 4);
        cmd({1'b1, p});
        for (int i = 0; i < 4; i++) begin
            dat(8'($urandom));
            p = next_text(p);
        end
        st({1'b0, p});
        cmd(8'h02);
        st(8'h00);
        chk(view.shift_off, 6'h00);
        cmd(8'h85);
        rdd(b);
        chk(b, m[0]);
        // display, cursor and blink bits
        cmd(8'h0F);
        chk({view.display_on, view.cursor_on, view.blink_on}, 3'h7);
        n = 0;
        repeat (40) @(posedge aclk) n += view.cursor_all_dots;
        chk(n > 0 && n < 40, 1'b1);
        cmd(8'h08);
        chk({view.display_on, view.cursor_on, view.blink_on}, 3'h0);
        dat(8'h44);
        st(8'h07);
        cmd(8'h85);
        rdd(b);
        chk(b, m[0]);
        // tall font and the strap; host keeps tall off in two-line mode
        cmd(8'h34);
        chk(view.font_tall, 1'b1);
        extended_set_pin <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(view.font_tall, 1'b0);
        extended_set_pin <= 1'b0;
        // extension table and symbol memory
        cmd(8'h39);
        chk(view.table_ext, 1'b1);
        cmd(8'h45);
        chk(view.sel, lcd_pkg::LCD_MEM_SYMBOL);
        // narrow bus round trip; polling follows the new width at once
        put(4'h0, 8'h28);
        nib4 = 1'b1;
        idle();
        chk(view.bus8, 1'b0);
        cmd(8'h80);
        dat(8'hC3);
        cmd(8'h80);
        rdd(b);
        chk(b, 8'hC3);
        put(4'h0, 8'h38);
        nib4 = 1'b0;
        idle();
        chk(view.bus8, 1'b1);
        // a write with no byte lane enabled is ignored
        wstrb <= 4'h0;
        host.wr(32'h0, 32'h02, r);
        chk(r, `LCD_RESP_OKAY);
        wstrb <= 4'hF;
        st(8'h01);
        // reset in mid-run restores wide bus and one line
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        st(8'h00);
        chk({view.bus8, view.two_line}, 2'b10);
        // unmapped offsets
        host.wr(32'h8, 32'h0, r);
        chk(r, `LCD_RESP_SLVERR);
        host.rd(32'hC, x, r);
        chk(r, `LCD_RESP_SLVERR);
        complete_run();
    end
endmodule : test_char_lcd_instruction_decoder
`default_nettype wire
